// file: logic/mtwc_pkg.sv
// constants, types and register map for the motor timer back end
// assumes a single peripheral clock and a plain strobe register port
package mtwc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam logic [7:0] A_WF_CTRL0 = 8'h00;
    localparam logic [7:0] A_WF_INIT0 = 8'h04;
    localparam logic [7:0] A_STOP_CTRL = 8'h10;
    localparam logic [7:0] A_STOP_STAT = 8'h11;
    localparam logic [7:0] A_CAP_CTRL = 8'h20;
    localparam logic [7:0] A_CAP_FLAG = 8'h21;
    localparam logic [7:0] A_CAP_VAL0 = 8'h24;
    localparam logic [7:0] A_CMP_CTRL0 = 8'h30;
    localparam logic [7:0] A_CMP_UP0 = 8'h34;
    localparam logic [7:0] A_CMP_DN0 = 8'h38;
    localparam logic [7:0] A_TRIG_SEL = 8'h3C;
    localparam logic [7:0] A_WF_STAT = 8'h3D;
    localparam logic [15:0] RST_FILTER_LEN = 16'h0004;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    typedef enum logic [2:0] {
        WF_THROUGH, WF_RT_GATE, WF_TIMER_GATE, WF_RT_DEAD, WF_PG_DEAD
    } mtwc_mode_type;
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] div;
        logic invert;
        logic gate_en;
        logic pg_sel;
        logic timer_en;
    } mtwc_wf_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mtwc_bus_type;
endpackage : mtwc_pkg

// file: logic/mtwc_top.sv
// motor timer back end: waveform pairs, stop filter, capture, conversion start
// assumes counter values and compare outputs come from the same clock domain
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - three channel pairs map compare outputs 0/1,2/3,4/5 to pins
// - each pair has a 16-bit timer on a divided clock, loaded from init value
// - unused timer runs as reload timer with one pulse output per pair
// - five modes: through, compare gated, timer gated, compare dead, pulse dead
// - pin levels come from compare outputs, pulse inputs and timer state
// - per pair selector picks pulse unit for gate and feedback
// - gate output commands external pulse generator to start
// - polarity inversion available in dead-time modes
// - filtered active-low stop input raises stop interrupt
// - while stop pending, pins take software stop levels
// - valid edge stores selected counter in 16-bit capture and flags
// - capture edge selectable: rising, falling, both
// - two capture units of two channels, each with source select and enable
// - three conversion compare channels, one per converter
// - two buffered 16-bit compares, start on counter match
// - compare start only in selected count direction
// - buffer enable/bypass and transfer moment selectable
// - zero-detect starts of all counters ORed per converter
// - per converter choose ORed counter start or compare start
// - six outputs: scan and priority start per converter
// - each unit selects one counter through its own selector
// - everything runs on the bus clock
module mtwc_top
    import mtwc_pkg::*;
#(
    parameter int NCNT = 3
)(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [NCNT*16-1:0] cnt_val_i,
    input wire logic [NCNT-1:0] cnt_down_i,
    input wire logic [NCNT*3-1:0] cnt_zero_i,
    input wire logic [5:0] compare_out_n_i,
    input wire logic [5:0] pulse_in_i,
    input wire logic emergency_stop_in_n_i,
    input wire logic [3:0] capture_in_n_i,
    output logic [5:0] pwm_pin_n_o,
    output logic [5:0] gate_o,
    output logic [2:0] timer_irq_o,
    output logic emergency_stop_irq_o,
    output logic [3:0] capture_irq_o,
    output logic [2:0] scan_start_o,
    output logic [2:0] prio_start_o
);
    function automatic logic [15:0] pick(input logic [1:0] s, input logic [NCNT*16-1:0] v);
        logic [15:0] r;
        r = v[15:0];
        for (int k = 0; k < NCNT; k++)
        begin
            if (s == 2'(k))
            begin
                r = v[k*16 +: 16];
            end
        end
        return r;
    endfunction : pick

    mtwc_bus_type bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    mtwc_wf_type wf_q [3];
    logic [15:0] init_q [3];
    logic [15:0] tmr_q [3];
    logic [7:0] pre_q [3];
    logic [2:0] tick_irq_q;
    logic [5:0] pin_q;
    logic [5:0] gate_q;
    logic [2:0] tmr_run;
    logic stop_en_q;
    logic [15:0] stop_len_q;
    logic [5:0] stop_lvl_q;
    logic [1:0] stop_sync_q;
    logic [15:0] stop_cnt_q;
    logic stop_flag_q;
    logic [1:0] cap_edge_q [4];
    logic [1:0] cap_src_q [2];
    logic [1:0] cap_en_q;
    logic [3:0] cap_s1_q;
    logic [3:0] cap_s2_q;
    logic [3:0] cap_old_q;
    logic [3:0] cap_flag_q;
    logic [15:0] cap_val_q [4];
    logic [3:0] cap_hit;
    logic [1:0] cmp_src_q [3];
    logic [2:0] cmp_en_q;
    logic [1:0] cmp_dir_q [3];
    logic [2:0] cmp_buf_q;
    logic [2:0] cmp_xfer_q;
    logic [15:0] cmp_up_b_q [3];
    logic [15:0] cmp_dn_b_q [3];
    logic [15:0] cmp_up_q [3];
    logic [15:0] cmp_dn_q [3];
    logic [2:0] cmp_hit;
    logic [2:0] cmp_xfer_ev;
    logic [2:0] or_zero;
    logic [5:0] trig_sel_q;
    logic [2:0] scan_q;
    logic [2:0] prio_q;
    logic [31:0] rdata_q;

    // prescalers and timers on the bus clock
    // divided tick and 16-bit reload count
    // reload pulse when timer not used by mode
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int p = 0; p < 3; p++)
            begin
                pre_q[p] <= 8'h00;
                tmr_q[p] <= 16'h0000;
            end
            tick_irq_q <= 3'h0;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                tick_irq_q[p] <= 1'b0;
                pre_q[p] <= pre_q[p] + 8'h01;
                if (!wf_q[p].timer_en)
                begin
                    tmr_q[p] <= 16'h0000;
                    pre_q[p] <= 8'h00;
                end
                else if (pre_q[p] == 8'((1 << wf_q[p].div) - 1))
                begin
                    pre_q[p] <= 8'h00;
                    if (tmr_q[p] == 16'h0000)
                    begin
                        tmr_q[p] <= init_q[p];
                        tick_irq_q[p] <= (wf_q[p].mode == 3'(WF_THROUGH)) || (wf_q[p].mode == 3'(WF_RT_GATE));
                    end
                    else
                    begin
                        tmr_q[p] <= tmr_q[p] - 16'h0001;
                    end
                end
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            tmr_run[p] = tmr_q[p] != 16'h0000;
        end
    end

    // pair p drives pins 2p and 2p+1 from compare outputs 2p, 2p+1
    // mode decode level sources inversion stop override
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_q <= 6'h00;
            gate_q <= 6'h00;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                logic a;
                logic b;
                logic pg;
                a = compare_out_n_i[2*p];
                b = compare_out_n_i[2*p+1];
                pg = pulse_in_i[2*p + int'(wf_q[p].pg_sel)];
                case (wf_q[p].mode)
                    3'(WF_RT_GATE):
                    begin
                        a = a & pg;
                        b = b & pg;
                    end
                    3'(WF_TIMER_GATE):
                    begin
                        a = tmr_run[p] & pg;
                        b = tmr_run[p] & pg;
                    end
                    3'(WF_RT_DEAD):
                    begin
                        // dead gap held while timer count is nonzero; the timer reloads on its own, not on edges
                        b = ~a & ~tmr_run[p];
                        a = a & ~tmr_run[p];
                    end
                    3'(WF_PG_DEAD):
                    begin
                        b = ~pg & ~tmr_run[p];
                        a = pg & ~tmr_run[p];
                    end
                    default:
                    begin
                        a = compare_out_n_i[2*p];
                    end
                endcase
                if (wf_q[p].invert && (wf_q[p].mode == 3'(WF_RT_DEAD) || wf_q[p].mode == 3'(WF_PG_DEAD)))
                begin
                    a = ~a;
                    b = ~b;
                end
                if (stop_flag_q)
                begin
                    a = stop_lvl_q[2*p];
                    b = stop_lvl_q[2*p+1];
                end
                pin_q[2*p] <= a;
                pin_q[2*p+1] <= b;
                gate_q[2*p] <= wf_q[p].gate_en & ~wf_q[p].pg_sel & (compare_out_n_i[2*p] | compare_out_n_i[2*p+1]);
                gate_q[2*p+1] <= wf_q[p].gate_en & wf_q[p].pg_sel & (compare_out_n_i[2*p] | compare_out_n_i[2*p+1]);
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            stop_sync_q <= 2'h3;
            stop_cnt_q <= 16'h0000;
            stop_flag_q <= 1'b0;
        end
        else
        begin
            stop_sync_q <= {stop_sync_q[0], emergency_stop_in_n_i};
            if (stop_sync_q[1])
            begin
                stop_cnt_q <= 16'h0000;
            end
            else if (stop_cnt_q != 16'hFFFF)
            begin
                stop_cnt_q <= stop_cnt_q + 16'h0001;
            end
            if (!stop_sync_q[1] && (!stop_en_q || stop_cnt_q + 16'h0001 >= stop_len_q))
            begin
                stop_flag_q <= 1'b1;
            end
            else if (bus.wr && bus.addr == A_STOP_STAT && bus.wdata[0])
            begin
                stop_flag_q <= 1'b0;
            end
        end
    end

    // edge select per channel capture sticky flag
    always_comb
    begin
        for (int c = 0; c < 4; c++)
        begin
            cap_hit[c] = cap_en_q[c/2] &&
                ((cap_edge_q[c][0] && cap_s2_q[c] && !cap_old_q[c]) ||
                 (cap_edge_q[c][1] && !cap_s2_q[c] && cap_old_q[c]));
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cap_s1_q <= 4'h0;
            cap_s2_q <= 4'h0;
            cap_old_q <= 4'h0;
            cap_flag_q <= 4'h0;
            for (int c = 0; c < 4; c++)
            begin
                cap_val_q[c] <= 16'h0000;
            end
        end
        else
        begin
            cap_s1_q <= capture_in_n_i;
            cap_s2_q <= cap_s1_q;
            cap_old_q <= cap_s2_q;
            for (int c = 0; c < 4; c++)
            begin
                if (cap_hit[c])
                begin
                    cap_val_q[c] <= pick(cap_src_q[c/2], cnt_val_i);
                    cap_flag_q[c] <= 1'b1;
                end
                else if (bus.wr && bus.addr == A_CAP_FLAG && bus.wdata[c])
                begin
                    cap_flag_q[c] <= 1'b0;
                end
            end
        end
    end

    // one channel per converter match direction
    always_comb
    begin
        for (int a = 0; a < 3; a++)
        begin
            logic [15:0] v;
            logic dn;
            v = pick(cmp_src_q[a], cnt_val_i);
            dn = cnt_down_i[cmp_src_q[a] < 2'(NCNT) ? cmp_src_q[a] : 2'h0];
            cmp_hit[a] = cmp_en_q[a] &&
                ((cmp_dir_q[a][0] && !dn && v == cmp_up_q[a]) ||
                 (cmp_dir_q[a][1] && dn && v == cmp_dn_q[a]));
            // transfer at zero or at an enabled match in the selected direction
            cmp_xfer_ev[a] = cmp_xfer_q[a] ? cmp_hit[a] : (v == 16'h0000);
        end
    end

    always_comb
    begin
        or_zero = 3'h0;
        for (int k = 0; k < NCNT; k++)
        begin
            or_zero = or_zero | cnt_zero_i[k*3 +: 3];
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            scan_q <= 3'h0;
            prio_q <= 3'h0;
        end
        else
        begin
            for (int a = 0; a < 3; a++)
            begin
                scan_q[a] <= trig_sel_q[a] ? cmp_hit[a] : or_zero[a];
                prio_q[a] <= trig_sel_q[a+3] ? cmp_hit[a] : or_zero[a];
            end
        end
    end

    // register writes; compare buffers live here because writes load them
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int p = 0; p < 3; p++)
            begin
                wf_q[p] <= '0;
                init_q[p] <= 16'h0000;
                cmp_src_q[p] <= 2'h0;
                cmp_dir_q[p] <= 2'h0;
                cmp_up_b_q[p] <= 16'h0000;
                cmp_dn_b_q[p] <= 16'h0000;
                cmp_up_q[p] <= 16'h0000;
                cmp_dn_q[p] <= 16'h0000;
            end
            for (int c = 0; c < 4; c++)
            begin
                cap_edge_q[c] <= 2'h1;
            end
            cap_src_q[0] <= 2'h0;
            cap_src_q[1] <= 2'h0;
            cap_en_q <= 2'h0;
            cmp_en_q <= 3'h0;
            cmp_buf_q <= 3'h0;
            cmp_xfer_q <= 3'h0;
            stop_en_q <= 1'b0;
            stop_len_q <= RST_FILTER_LEN;
            stop_lvl_q <= 6'h00;
            trig_sel_q <= 6'h00;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                if (bus.wr && bus.addr == A_WF_CTRL0 + 8'(p))
                begin
                    wf_q[p] <= bus.wdata[9:0];
                end
                if (bus.wr && bus.addr == A_WF_INIT0 + 8'(p))
                begin
                    init_q[p] <= bus.wdata[15:0];
                end
                if (bus.wr && bus.addr == A_CMP_CTRL0 + 8'(p))
                begin
                    cmp_en_q[p] <= bus.wdata[0];
                    cmp_dir_q[p] <= bus.wdata[2:1];
                    cmp_buf_q[p] <= bus.wdata[3];
                    cmp_xfer_q[p] <= bus.wdata[4];
                    cmp_src_q[p] <= bus.wdata[6:5];
                end
                if (bus.wr && bus.addr == A_CMP_UP0 + 8'(p))
                begin
                    cmp_up_b_q[p] <= bus.wdata[15:0];
                end
                if (bus.wr && bus.addr == A_CMP_DN0 + 8'(p))
                begin
                    cmp_dn_b_q[p] <= bus.wdata[15:0];
                end
                // bypass copies at once, buffered copies on event
                if (!cmp_buf_q[p] || cmp_xfer_ev[p])
                begin
                    cmp_up_q[p] <= cmp_up_b_q[p];
                    cmp_dn_q[p] <= cmp_dn_b_q[p];
                end
            end
            if (bus.wr && bus.addr == A_CAP_CTRL)
            begin
                for (int c = 0; c < 4; c++)
                begin
                    cap_edge_q[c] <= bus.wdata[2*c +: 2];
                end
                cap_src_q[0] <= bus.wdata[9:8];
                cap_src_q[1] <= bus.wdata[11:10];
                cap_en_q <= bus.wdata[13:12];
            end
            if (bus.wr && bus.addr == A_STOP_CTRL)
            begin
                stop_en_q <= bus.wdata[0];
                stop_lvl_q <= bus.wdata[7:2];
                stop_len_q <= bus.wdata[31:16];
            end
            if (bus.wr && bus.addr == A_TRIG_SEL)
            begin
                trig_sel_q <= bus.wdata[5:0];
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise or when unmapped
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_q <= RST_ZERO;
        end
        else
        begin
            rdata_q <= RST_ZERO;
            if (bus.rd)
            begin
                if (bus.addr == A_STOP_STAT)
                begin
                    rdata_q <= {31'h0, stop_flag_q};
                end
                else if (bus.addr == A_CAP_FLAG)
                begin
                    rdata_q <= {28'h0, cap_flag_q};
                end
                else if (bus.addr >= A_CAP_VAL0 && bus.addr < A_CAP_VAL0 + 8'h04)
                begin
                    rdata_q <= {16'h0, cap_val_q[2'(bus.addr - A_CAP_VAL0)]};
                end
                else if (bus.addr == A_WF_STAT)
                begin
                    rdata_q <= {13'h0, tmr_run, 10'h0, pin_q};
                end
                else if (bus.addr == A_TRIG_SEL)
                begin
                    rdata_q <= {26'h0, trig_sel_q};
                end
            end
        end
    end

    assign rdata_o = rdata_q;
    assign pwm_pin_n_o = pin_q;
    assign gate_o = gate_q;
    assign timer_irq_o = tick_irq_q;
    assign emergency_stop_irq_o = stop_flag_q;
    assign capture_irq_o = cap_flag_q;
    assign scan_start_o = scan_q;
    assign prio_start_o = prio_q;
endmodule : mtwc_top

// file: dv/mtwc_pulse_model.sv
// pulse generator stand-in for the far side of the waveform pairs
// assumes gate levels from mtwc_top on the same clock
`timescale 1ns/10ps
module mtwc_pulse_model (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [5:0] gate_i,
    output logic [5:0] pulse_o
);
    logic [1:0] ph_q;
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ph_q <= 2'h0;
            pulse_o <= 6'h00;
        end
        else
        begin
            ph_q <= ph_q + 2'h1;
            pulse_o <= gate_i & {6{ph_q[1]}};
        end
    end
endmodule : mtwc_pulse_model

// file: dv/mtwc_checker.sv
// port assertions for the motor timer back end
// assumes bind onto mtwc_top, one clock, async high reset
`timescale 1ns/10ps
module mtwc_checker
    import mtwc_pkg::*;
#(
    parameter int NCNT = 3
)(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [NCNT*3-1:0] cnt_zero_i,
    input wire logic emergency_stop_in_n_i,
    input wire logic emergency_stop_irq_o,
    input wire logic [3:0] capture_irq_o,
    input wire logic [2:0] scan_start_o,
    input wire logic [2:0] prio_start_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [2:0] zero_or;
    logic [5:0] sel_q;
    logic sel_wr;
    assign zero_or = cnt_zero_i[2:0] | cnt_zero_i[5:3] | cnt_zero_i[8:6];
    assign sel_wr = wr_i && addr_i == A_TRIG_SEL;
    // selector copy, so the or path is only judged while it is chosen
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            sel_q <= 6'h00;
        else if (sel_wr)
            sel_q <= wdata_i[5:0];
    end
    sequence s_pin_high;
        emergency_stop_in_n_i [*4];
    endsequence
    sequence s_pin_low;
        !emergency_stop_in_n_i [*8];
    endsequence
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (rd_i && addr_i == 8'hFF |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_cap_flag_sticky: assert property (!(wr_i && addr_i == A_CAP_FLAG) |=>
        (capture_irq_o & $past(capture_irq_o)) == $past(capture_irq_o))
        else $error("capture flag dropped without clear");
    a_cap_flag_read: assert property (rd_i && addr_i == A_CAP_FLAG |=>
        rdata_o == {28'h0000000, $past(capture_irq_o)})
        else $error("capture flag read mismatch");
    a_stop_flag_sticky: assert property (emergency_stop_irq_o && !(wr_i && addr_i == A_STOP_STAT) |=>
        emergency_stop_irq_o)
        else $error("stop flag dropped without clear");
    a_stop_stays_quiet: assert property (s_pin_high ##0 !emergency_stop_irq_o |=> !emergency_stop_irq_o)
        else $error("stop flag raised with input high");
    a_stop_raises_flag: assert property (s_pin_low |=> emergency_stop_irq_o)
        else $error("stop flag missing after long low input");
    a_stop_status_read: assert property (rd_i && addr_i == A_STOP_STAT |=>
        rdata_o == {31'h00000000, $past(emergency_stop_irq_o)})
        else $error("stop status read mismatch");
    a_or_start_path: assert property (sel_q == 6'h00 && !sel_wr |=>
        scan_start_o == $past(zero_or) && prio_start_o == $past(zero_or))
        else $error("or combined start mismatch");
endmodule : mtwc_checker
bind mtwc_top mtwc_checker #(.NCNT(NCNT)) mtwc_checker_i (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .cnt_zero_i(cnt_zero_i),
    .emergency_stop_in_n_i(emergency_stop_in_n_i),
    .emergency_stop_irq_o(emergency_stop_irq_o),
    .capture_irq_o(capture_irq_o),
    .scan_start_o(scan_start_o),
    .prio_start_o(prio_start_o)
);

// file: dv/mtwc_top_tb.sv
// self-checking bench for the motor timer back end
// assumes the pulse model on the gate lines and bound port checker
`timescale 1ns/10ps
module mtwc_top_tb;
    import mtwc_pkg::*;
    logic clock_i, reset_i, wr_i, rd_i, emergency_stop_in_n_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [47:0] cnt_val_i;
    logic [2:0] cnt_down_i, timer_irq_o, scan_start_o, prio_start_o;
    logic [8:0] cnt_zero_i;
    logic [5:0] compare_out_n_i, pulse_in_i, pwm_pin_n_o, gate_o;
    logic emergency_stop_irq_o;
    logic [3:0] capture_in_n_i, capture_irq_o;
    int num_errors = 0;
    int samples_checked = 0;
    int pulses;
    logic [15:0] cap_exp [4];
    mtwc_top #(.NCNT(3)) mtwc_top_i (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cnt_val_i(cnt_val_i),
        .cnt_down_i(cnt_down_i), .cnt_zero_i(cnt_zero_i), .compare_out_n_i(compare_out_n_i),
        .pulse_in_i(pulse_in_i), .emergency_stop_in_n_i(emergency_stop_in_n_i),
        .capture_in_n_i(capture_in_n_i), .pwm_pin_n_o(pwm_pin_n_o), .gate_o(gate_o),
        .timer_irq_o(timer_irq_o), .emergency_stop_irq_o(emergency_stop_irq_o),
        .capture_irq_o(capture_irq_o), .scan_start_o(scan_start_o), .prio_start_o(prio_start_o));
    mtwc_pulse_model mtwc_pulse_model_i (.clock_i(clock_i), .reset_i(reset_i), .gate_i(gate_o),
        .pulse_o(pulse_in_i));
    initial
    begin
        clock_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp, what);
    endtask : rd_chk
    task automatic stop_pin(input logic lvl, input int n);
        @(posedge clock_i);
        emergency_stop_in_n_i <= lvl;
        repeat (n) @(posedge clock_i);
    endtask : stop_pin
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        #50us;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        reset_i = 1'b1;
        {wr_i, rd_i, addr_i, wdata_i, cnt_down_i, cnt_zero_i} = '0;
        cnt_val_i = 48'h0;
        compare_out_n_i = 6'h00;
        emergency_stop_in_n_i = 1'b1;
        capture_in_n_i = 4'h0;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        rd_chk(A_CAP_FLAG, 32'h0, "flags after reset");
        rd_chk(8'hFF, 32'h0, "unmapped read");
        // edge select and source per unit
        cnt_val_i <= {16'hA002, 16'hA001, 16'hA000};
        wr(A_CAP_CTRL, 32'h0000_3979);
        capture_in_n_i <= 4'hF;
        repeat (6) @(posedge clock_i);
        rd_chk(A_CAP_FLAG, 32'hD, "rising flags");
        cap_exp = '{16'hA001, 16'h0000, 16'hA002, 16'hA002};
        for (int c = 0; c < 4; c++)
            rd_chk(A_CAP_VAL0 + 8'(c), {16'h0, cap_exp[c]}, "captured value");
        wr(A_CAP_FLAG, 32'hF);
        rd_chk(A_CAP_FLAG, 32'h0, "flags cleared");
        cnt_val_i <= {16'hB002, 16'hB001, 16'hB000};
        wr(A_CAP_CTRL, 32'h0000_1979);
        capture_in_n_i <= 4'h0;
        repeat (6) @(posedge clock_i);
        rd_chk(A_CAP_FLAG, 32'h2, "falling flags, unit one off");
        rd_chk(A_CAP_VAL0 + 8'h1, 32'h0000_B001, "latest capture");
        rd_chk(A_CAP_VAL0, 32'h0000_A001, "value held");
        rd_chk(A_CAP_VAL0 + 8'h2, 32'h0000_A002, "disabled unit held");
        $display("test capture done");
        // stop with filter off, stop levels 6'h2A
        wr(A_STOP_CTRL, 32'h0004_00A8);
        stop_pin(1'b0, 6);
        chk(emergency_stop_irq_o, 1'b1, "stop flag");
        chk(pwm_pin_n_o, 6'h2A, "stop levels on pins");
        wr(A_STOP_STAT, 32'h1);
        rd_chk(A_STOP_STAT, 32'h1, "set wins while low");
        stop_pin(1'b1, 4);
        wr(A_STOP_STAT, 32'h1);
        rd_chk(A_STOP_STAT, 32'h0, "stop cleared");
        // short glitch refused, long low accepted
        wr(A_STOP_CTRL, 32'h0004_00A9);
        stop_pin(1'b0, 2);
        stop_pin(1'b1, 8);
        chk(emergency_stop_irq_o, 1'b0, "glitch filtered");
        stop_pin(1'b0, 12);
        chk(emergency_stop_irq_o, 1'b1, "filtered stop");
        stop_pin(1'b1, 4);
        wr(A_STOP_STAT, 32'h1);
        $display("test stop done");
        // every counter zero start to every converter
        wr(A_TRIG_SEL, 32'h0);
        for (int k = 0; k < 9; k++)
        begin
            @(posedge clock_i);
            cnt_zero_i <= 9'h1 << k;
            @(posedge clock_i);
            cnt_zero_i <= 9'h0;
            #1;
            chk({prio_start_o, scan_start_o}, {2{3'h1 << (k % 3)}}, "zero start");
        end
        // up match starts, down direction refused
        cnt_val_i <= {3{16'h0122}};
        for (int a = 0; a < 3; a++)
        begin
            wr(A_CMP_UP0 + 8'(a), 32'h0000_0123);
            wr(A_CMP_CTRL0 + 8'(a), 32'h3);
        end
        wr(A_TRIG_SEL, 32'h3F);
        for (int d = 0; d < 2; d++)
        begin
            cnt_down_i <= {3{d[0]}};
            cnt_val_i <= {3{16'h0122}};
            repeat (3) @(posedge clock_i);
            cnt_val_i <= {3{16'h0123}};
            @(posedge clock_i);
            cnt_val_i <= {3{16'h0124}};
            #1;
            chk({prio_start_o, scan_start_o}, d == 0 ? 6'h3F : 6'h00, "compare start");
        end
        wr(A_TRIG_SEL, 32'h0);
        $display("test conversion start done");
        // through mode pins follow compare outputs
        wr(A_WF_CTRL0, 32'h0);
        compare_out_n_i <= 6'h15;
        repeat (3) @(posedge clock_i);
        chk(pwm_pin_n_o, 6'h15, "through pins");
        rd_chk(A_WF_STAT, 32'h15, "pin status");
        // reload timer pulses on pair zero only
        wr(A_WF_INIT0, 32'h4);
        wr(A_WF_CTRL0, 32'h001);
        pulses = 0;
        repeat (60)
        begin
            @(posedge clock_i);
            #1;
            chk(timer_irq_o[2:1], 2'h0, "idle pair timers");
            pulses += int'(timer_irq_o[0] === 1'b1);
        end
        chk(pulses > 0, 1'b1, "reload pulses");
        // gate goes to unit a, then to unit b when selected
        wr(A_WF_CTRL0, 32'h004);
        repeat (2) @(posedge clock_i);
        #1;
        chk(gate_o, 6'h01, "gate unit a");
        wr(A_WF_CTRL0, 32'h006);
        repeat (2) @(posedge clock_i);
        #1;
        chk(gate_o, 6'h02, "gate unit b");
        $display("test waveform done");
        wrap_up();
    end
endmodule : mtwc_top_tb
